// [common/smi_clock_stop_params.svh]
// Offsets, field positions, reset values and timing counts of the power block.
`ifndef SMI_CLOCK_STOP_PARAMS_SVH
`define SMI_CLOCK_STOP_PARAMS_SVH
`define CFG_SMI_CONTROL     8'ha0
`define CFG_SMI_ENABLE      8'ha2
`define CFG_BREAK_ENABLE    8'ha4
`define CFG_SCALE_RUN       8'ha8
`define CFG_SCALE_STOP      8'ha9
`define CFG_SMI_CAUSE       8'haa
`define CFG_RESET_CONTROL   8'hac
`define CFG_HANDSHAKE       8'h6a
`define IO_APM_COMMAND      8'hb2
`define IO_APM_MAILBOX      8'hb3
`define CTL_GLOBAL_SMI      0
`define CTL_STOP_ENABLE     1
`define CTL_SCALE_ENABLE    2
`define SRC_EXTERNAL        0
`define SRC_APM             1
`define RC_HARD_RESET       2
`define RST_SMI_CONTROL     3'h0
`define RST_SMI_ENABLE      2'h0
`define RST_BREAK_ENABLE    8'h00
`define RST_SCALE_TIME      8'h00
`define CLK_MHZ             250
`define TICK_US             32
`define TICK_CYCLES         (`TICK_US * `CLK_MHZ)
`define HARD_RESET_US       1000
`define HARD_RESET_CYCLES   (`HARD_RESET_US * `CLK_MHZ)
`define PCI_CPU_GAP_US      1500
`define PCI_CPU_GAP_CYCLES  (`PCI_CPU_GAP_US * `CLK_MHZ)
`endif

// [common/smi_clock_stop_pkg.sv]
// Types shared by the power management and reset block.
package smi_clock_stop_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        ioSpace;
    logic        isaMaster;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } acc_req_t;
  typedef struct packed {
    logic        rvalid;
    logic [15:0] rdata;
    logic        claim;
    logic        forward;
  } acc_resp_t;
  typedef enum {PWR_OFF, HARD_RST, PCI_GAP, RUN} rst_state_t;
endpackage

// [design/pin_sync3.sv]
// Three flip-flop synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] next_syncOut;

  always_comb
  begin
    next_syncOut = syncOut;
    for (int i = 0; i < W; i++)
    begin
      if (ff2[i] == ff3[i])
        next_syncOut[i] = ff3[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ff1     <= '0;
      ff2     <= '0;
      ff3     <= '0;
      syncOut <= '0;
    end
    else
    begin
      ff1     <= pinIn;
      ff2     <= ff1;
      ff3     <= ff2;
      syncOut <= next_syncOut;
    end
  end
endmodule

// [design/smi_clock_stop_reset_control.sv]
// SMI generation, CPU stop-clock control with clock scaling, and system reset sequencing.
`timescale 1ns/100ps
`include "smi_clock_stop_params.svh"

module smi_clock_stop_reset_control #(
  parameter int TICK_CYCLES  = `TICK_CYCLES,
  parameter int HARD_CYCLES  = `HARD_RESET_CYCLES,
  parameter int GAP_CYCLES   = `PCI_CPU_GAP_CYCLES,
  parameter bit APIC_MODE    = 1'b0
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire smi_clock_stop_pkg::acc_req_t  accReq,
  output smi_clock_stop_pkg::acc_resp_t      accResp,
  input  wire logic                          externalSmiRequestN,
  input  wire logic [7:0]                    breakEvents,
  input  wire logic                          powerGoodIn,
  input  wire logic                          sysclkStrap,
  input  wire logic                          tcStrap,
  input  wire logic                          intrIn,
  input  wire logic                          nmiIn,
  input  wire logic                          ignoreNumericErrorIn,
  input  wire logic                          apicAcknowledgeIn,
  output logic                               systemMgmtIrqOutN,
  output logic                               cpuStopClockN,
  output logic                               cpuResetOut,
  output logic                               intrOut,
  output logic                               nmiOut,
  output logic                               ignoreNumericErrorN,
  output logic                               pciResetOutN,
  output logic                               isaResetDrive,
  output logic                               isaClkDivide4,
  output logic                               isaDmaMode
);
  import smi_clock_stop_pkg::*;

  logic [11:0] syncIn;
  logic        extActive;
  logic [7:0]  breakSync;
  logic        powerGood;
  logic        strapClk;
  logic        strapTc;
  logic        tick;

  pin_sync3 #(.W(12)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   ({~externalSmiRequestN, breakEvents, powerGoodIn, sysclkStrap,
               tcStrap}),
    .syncOut (syncIn)
  );
  assign extActive = syncIn[11];
  assign breakSync = syncIn[10:3];
  assign powerGood = syncIn[2];
  assign strapClk  = syncIn[1];
  assign strapTc   = syncIn[0];

  tick_divider #(.PERIOD(TICK_CYCLES)) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  function automatic logic apmHit(input acc_req_t r, input logic [7:0] off);
    return r.ioSpace && !r.isaMaster && (r.addr == off);
  endfunction

  function automatic logic cfgHit(input acc_req_t r, input logic [7:0] off);
    return !r.ioSpace && (r.addr == off);
  endfunction

  // Register state.
  logic [2:0]  smiControl;
  logic [1:0]  smiEnable;
  logic [1:0]  smiCause;
  logic [7:0]  breakEnable;
  logic [7:0]  scaleRun;
  logic [7:0]  scaleStop;
  logic [7:0]  apmCommand;
  logic [7:0]  apmMailbox;
  logic [7:0]  handshakeHigh;
  logic        stopSw;
  logic        scalePhaseStop;
  logic [7:0]  scaleCount;
  logic        hardReq;
  logic [2:0]  next_smiControl;
  logic [1:0]  next_smiEnable;
  logic [1:0]  next_smiCause;
  logic [7:0]  next_breakEnable;
  logic [7:0]  next_scaleRun;
  logic [7:0]  next_scaleStop;
  logic [7:0]  next_apmCommand;
  logic [7:0]  next_apmMailbox;
  logic [7:0]  next_handshakeHigh;
  logic        next_stopSw;
  logic        next_scalePhaseStop;
  logic [7:0]  next_scaleCount;
  logic        next_hardReq;
  acc_resp_t   next_accResp;
  logic        cmdWr;
  logic        cmdRd;
  logic        boxWr;
  logic        breakHit;
  logic        scaleOn;
  logic [7:0]  scaleLimit;

  always_comb
  begin
    cmdWr    = accReq.wr && apmHit(accReq, `IO_APM_COMMAND);
    cmdRd    = accReq.rd && apmHit(accReq, `IO_APM_COMMAND);
    boxWr    = accReq.wr && apmHit(accReq, `IO_APM_MAILBOX);
    breakHit = |(breakSync & breakEnable);
    scaleOn  = smiControl[`CTL_SCALE_ENABLE];
    next_smiControl    = smiControl;
    next_smiEnable     = smiEnable;
    next_breakEnable   = breakEnable;
    next_scaleRun      = scaleRun;
    next_scaleStop     = scaleStop;
    next_apmCommand    = apmCommand;
    next_apmMailbox    = apmMailbox;
    next_handshakeHigh = handshakeHigh;
    next_hardReq       = 1'b0;
    next_smiCause      = smiCause;
    next_stopSw        = stopSw;
    next_accResp       = '0;
    if (accReq.wr && !accReq.ioSpace)
    begin
      if (cfgHit(accReq, `CFG_SMI_CONTROL))
        next_smiControl = accReq.wdata[2:0];
      if (cfgHit(accReq, `CFG_SMI_ENABLE))
        next_smiEnable = accReq.wdata[1:0];
      if (cfgHit(accReq, `CFG_BREAK_ENABLE))
        next_breakEnable = accReq.wdata[7:0];
      if (cfgHit(accReq, `CFG_SCALE_RUN))
        next_scaleRun = accReq.wdata[7:0];
      if (cfgHit(accReq, `CFG_SCALE_STOP))
        next_scaleStop = accReq.wdata[7:0];
      if (cfgHit(accReq, `CFG_HANDSHAKE))
        next_handshakeHigh = accReq.wdata[15:8];
      if (cfgHit(accReq, `CFG_RESET_CONTROL))
        next_hardReq = accReq.wdata[`RC_HARD_RESET];
      // Cause bits clear by writing ones.
      if (cfgHit(accReq, `CFG_SMI_CAUSE))
        next_smiCause = smiCause & ~accReq.wdata[1:0];
    end
    if (boxWr)
      next_apmMailbox = accReq.wdata[7:0];
    if (cmdWr)
      next_apmCommand = accReq.wdata[7:0];
    // Cause bit set, winning over clear
    if (extActive && smiEnable[`SRC_EXTERNAL])
      next_smiCause[`SRC_EXTERNAL] = 1'b1;
    if (cmdWr)
      next_smiCause[`SRC_APM] = 1'b1;
    if (cmdRd && smiControl[`CTL_STOP_ENABLE])
      next_stopSw = 1'b1;
    if (stopSw && breakHit)
      next_stopSw = 1'b0;
    if (cmdWr || !next_smiControl[`CTL_STOP_ENABLE])
      next_stopSw = 1'b0;
    if ((accReq.wr || accReq.rd) && (apmHit(accReq, `IO_APM_COMMAND) ||
        apmHit(accReq, `IO_APM_MAILBOX)))
    begin
      next_accResp.claim   = 1'b1;
      next_accResp.forward = 1'b1;
    end
    if (accReq.rd)
    begin
      next_accResp.rvalid = 1'b1;
      if (apmHit(accReq, `IO_APM_COMMAND))
        next_accResp.rdata = {8'h00, apmCommand};
      else if (apmHit(accReq, `IO_APM_MAILBOX))
        next_accResp.rdata = {8'h00, apmMailbox};
      else if (cfgHit(accReq, `CFG_SMI_CONTROL))
        next_accResp.rdata = {13'h0000, smiControl};
      else if (cfgHit(accReq, `CFG_SMI_ENABLE))
        next_accResp.rdata = {14'h0000, smiEnable};
      else if (cfgHit(accReq, `CFG_SMI_CAUSE))
        next_accResp.rdata = {14'h0000, smiCause};
      else if (cfgHit(accReq, `CFG_BREAK_ENABLE))
        next_accResp.rdata = {8'h00, breakEnable};
      else if (cfgHit(accReq, `CFG_SCALE_RUN))
        next_accResp.rdata = {8'h00, scaleRun};
      else if (cfgHit(accReq, `CFG_SCALE_STOP))
        next_accResp.rdata = {8'h00, scaleStop};
      else if (cfgHit(accReq, `CFG_HANDSHAKE))
        next_accResp.rdata = {handshakeHigh, 6'h00, extActive, ~systemMgmtIrqOutN};
    end
  end

  always_comb
  begin
    scaleLimit          = scalePhaseStop ? scaleStop : scaleRun;
    next_scalePhaseStop = scalePhaseStop;
    next_scaleCount     = scaleCount;
    if (!scaleOn || breakHit)
    begin
      next_scalePhaseStop = 1'b0;
      next_scaleCount     = 8'h00;
    end
    else if (scaleCount >= scaleLimit)
    begin
      next_scalePhaseStop = ~scalePhaseStop;
      next_scaleCount     = 8'h00;
    end
    else if (tick)
      next_scaleCount = scaleCount + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smiControl     <= `RST_SMI_CONTROL;
      smiEnable      <= `RST_SMI_ENABLE;
      smiCause       <= 2'h0;
      breakEnable    <= `RST_BREAK_ENABLE;
      scaleRun       <= `RST_SCALE_TIME;
      scaleStop      <= `RST_SCALE_TIME;
      apmCommand     <= 8'h00;
      apmMailbox     <= 8'h00;
      handshakeHigh  <= 8'h00;
      hardReq        <= 1'b0;
      stopSw         <= 1'b0;
      scalePhaseStop <= 1'b0;
      scaleCount     <= 8'h00;
      accResp        <= '0;
    end
    else
    begin
      smiControl     <= next_smiControl;
      smiEnable      <= next_smiEnable;
      smiCause       <= next_smiCause;
      breakEnable    <= next_breakEnable;
      scaleRun       <= next_scaleRun;
      scaleStop      <= next_scaleStop;
      apmCommand     <= next_apmCommand;
      apmMailbox     <= next_apmMailbox;
      handshakeHigh  <= next_handshakeHigh;
      hardReq        <= next_hardReq;
      stopSw         <= next_stopSw;
      scalePhaseStop <= next_scalePhaseStop;
      scaleCount     <= next_scaleCount;
      accResp        <= next_accResp;
    end
  end

  // Reset sequencer and pin drive.
  rst_state_t  state;
  rst_state_t  next_state;
  logic [19:0] rstCount;
  logic [19:0] next_rstCount;
  logic        next_isaClkDivide4;
  logic        next_isaDmaMode;
  logic        smiWanted;
  logic        pciRstAct;

  always_comb
  begin
    next_state         = state;
    next_rstCount      = rstCount + 20'h00001;
    next_isaClkDivide4 = isaClkDivide4;
    next_isaDmaMode    = isaDmaMode;
    case (state)
      PWR_OFF:
      begin
        next_rstCount = 20'h00000;
        if (powerGood)
          next_state = HARD_RST;
      end
      HARD_RST:
      begin
        next_isaClkDivide4 = ~strapClk;
        next_isaDmaMode    = strapTc;
        if (rstCount >= 20'(HARD_CYCLES - 1))
        begin
          next_state    = PCI_GAP;
          next_rstCount = 20'h00000;
        end
      end
      PCI_GAP:
      begin
        if (rstCount >= 20'(GAP_CYCLES - 1))
          next_state = RUN;
      end
      RUN:
        next_rstCount = 20'h00000;
      default:
        next_state = PWR_OFF;
    endcase
    if (hardReq && state != PWR_OFF)
    begin
      next_state    = HARD_RST;
      next_rstCount = 20'h00000;
    end
    if (!powerGood)
      next_state = PWR_OFF;
    smiWanted = smiControl[`CTL_GLOBAL_SMI] && |(smiCause & (smiEnable | 2'b10));
    pciRstAct = (state == PWR_OFF) || (state == HARD_RST);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state               <= PWR_OFF;
      rstCount            <= 20'h00000;
      isaClkDivide4       <= 1'b0;
      isaDmaMode          <= 1'b0;
      systemMgmtIrqOutN   <= 1'b0;
      cpuStopClockN       <= 1'b0;
      cpuResetOut         <= 1'b0;
      intrOut             <= 1'b0;
      nmiOut              <= 1'b0;
      ignoreNumericErrorN <= 1'b0;
      pciResetOutN        <= 1'b0;
      isaResetDrive       <= 1'b1;
    end
    else
    begin
      state         <= next_state;
      rstCount      <= next_rstCount;
      isaClkDivide4 <= next_isaClkDivide4;
      isaDmaMode    <= next_isaDmaMode;
      isaResetDrive <= pciRstAct;
      pciResetOutN  <= APIC_MODE ? apicAcknowledgeIn : ~pciRstAct;
      if (state == PWR_OFF)
      begin
        systemMgmtIrqOutN   <= 1'b0;
        cpuStopClockN       <= 1'b0;
        cpuResetOut         <= 1'b0;
        intrOut             <= 1'b0;
        nmiOut              <= 1'b0;
        ignoreNumericErrorN <= 1'b0;
      end
      else
      begin
        systemMgmtIrqOutN   <= ~smiWanted;
        cpuStopClockN       <= ~(stopSw || (scaleOn && scalePhaseStop));
        cpuResetOut         <= (state != RUN);
        intrOut             <= intrIn;
        nmiOut              <= nmiIn;
        ignoreNumericErrorN <= ~ignoreNumericErrorIn;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_ext_smi;
    (extActive && smiEnable[0] && smiControl[0] && state == RUN) |-> ##[1:2] !systemMgmtIrqOutN;
  endproperty
  a_ext_smi: assert property (p_ext_smi) else $error("external request gave no SMI");
  property p_apm_cause;
    cmdWr |=> smiCause[1];
  endproperty
  a_apm_cause: assert property (p_apm_cause) else $error("APM write set no cause");
  property p_mailbox;
    boxWr |=> apmMailbox == $past(accReq.wdata[7:0]);
  endproperty
  a_mailbox: assert property (p_mailbox) else $error("mailbox lost its byte");
  property p_claim;
    (cmdWr || cmdRd) |=> accResp.claim && accResp.forward;
  endproperty
  a_claim: assert property (p_claim) else $error("APM access not claimed");
  property p_isa_blocked;
    (accReq.isaMaster && accReq.ioSpace) |=> !accResp.claim && $stable(apmMailbox);
  endproperty
  a_isa_blocked: assert property (p_isa_blocked) else $error("ISA master reached APM");
  property p_stop_read;
    (cmdRd && smiControl[1] && !breakHit && !accReq.wr) |=> stopSw;
  endproperty
  a_stop_read: assert property (p_stop_read) else $error("command read did not stop");
  property p_break;
    (stopSw && breakHit) |=> !stopSw ##1 cpuStopClockN || state == PWR_OFF;
  endproperty
  a_break: assert property (p_break) else $error("break left stop-clock on");
  property p_sw_release;
    (!smiControl[1] || cmdWr) |=> !stopSw;
  endproperty
  a_sw_release: assert property (p_sw_release) else $error("stop-clock not released");
  property p_scale_start;
    $rose(scaleOn) |-> !scalePhaseStop;
  endproperty
  a_scale_start: assert property (p_scale_start) else $error("scaling began stopped");
  property p_power_off;
    state == PWR_OFF |=> !cpuResetOut && !systemMgmtIrqOutN && !cpuStopClockN && isaResetDrive;
  endproperty
  a_power_off: assert property (p_power_off) else $error("CPU pins not low");
  property p_gap;
    state == PCI_GAP && rstCount < 20'h00002 |=> ##1 cpuResetOut && !isaResetDrive;
  endproperty
  a_gap: assert property (p_gap) else $error("reset order wrong");
  property p_global;
    (!smiControl[0] && state != PWR_OFF) |=> systemMgmtIrqOutN;
  endproperty
  a_global: assert property (p_global) else $error("SMI without global enable");
  c_smi: cover property ($fell(systemMgmtIrqOutN));
  c_scale: cover property (scaleOn && $rose(scalePhaseStop));
  c_run: cover property ($rose(state == RUN));
  c_break: cover property (stopSw && breakHit);
endmodule

// [design/tick_divider.sv]
// Divider that gives a one-cycle enable pulse every PERIOD clock cycles.
`timescale 1ns/100ps
module tick_divider #(
  parameter int PERIOD = 8000
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      tick
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_tick;

  always_comb
  begin
    next_tick  = 1'b0;
    next_count = count + 16'h0001;
    if (count >= 16'(PERIOD - 1))
    begin
      next_count = 16'h0000;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule

// [test/cpu_host_model.sv]
// Host CPU and board strap model facing the power block.
`timescale 1ns/100ps
module cpu_host_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic cpuStopClockN,
  input  wire logic isaResetDrive,
  input  wire logic strapSel,
  output logic      stopGrant,
  output logic      sysclkStrap
);
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      stopGrant <= 1'b0;
    else
      stopGrant <= ~cpuStopClockN;
  // Reset-only strap driver.
  // The released strap shows the opposite level so a late sample is caught.
  assign sysclkStrap = isaResetDrive ? strapSel : ~strapSel;
endmodule

// [test/tb_smi_clock_stop_reset_control.sv]
// Directed testbench for the SMI, stop-clock and reset block.
`timescale 1ns/100ps
`include "smi_clock_stop_params.svh"
module tb_smi_clock_stop_reset_control;
  import smi_clock_stop_pkg::*;
  localparam int TICK = 4;
  localparam int GAP  = 20;
  logic      sys_clk  = 1'b0;
  logic      rst_n    = 1'b0;
  logic      extN     = 1'b1;
  logic      pg       = 1'b0;
  logic      intrIn   = 1'b0;
  logic      strapSel = 1'b0;
  logic      tc       = 1'b1;
  logic [7:0] brk     = 8'h00;
  acc_req_t  req      = '0;
  acc_resp_t resp;
  acc_resp_t last;
  logic      smiN, stopN, cpu_reset_out, intrOut, nmiOut, ignN;
  logic      pciRstN, isaRst, div4, dma, stopGrant, strap;
  int        failCount      = 0;
  int        samplesChecked = 0;
  int        cycles         = 0;
  int        n;

  always #2 sys_clk = ~sys_clk;

  smi_clock_stop_reset_control #(.TICK_CYCLES(TICK), .HARD_CYCLES(10), .GAP_CYCLES(GAP)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .accReq(req), .accResp(resp),
    .externalSmiRequestN(extN), .breakEvents(brk), .powerGoodIn(pg),
    .sysclkStrap(strap), .tcStrap(tc), .intrIn(intrIn), .nmiIn(1'b0),
    .ignoreNumericErrorIn(1'b0), .apicAcknowledgeIn(1'b0),
    .systemMgmtIrqOutN(smiN), .cpuStopClockN(stopN), .cpuResetOut(cpu_reset_out),
    .intrOut(intrOut), .nmiOut(nmiOut), .ignoreNumericErrorN(ignN),
    .pciResetOutN(pciRstN), .isaResetDrive(isaRst), .isaClkDivide4(div4),
    .isaDmaMode(dma));

  cpu_host_model partner (
    .sys_clk(sys_clk), .rst_n(rst_n), .cpuStopClockN(stopN),
    .isaResetDrive(isaRst), .strapSel(strapSel), .stopGrant(stopGrant),
    .sysclkStrap(strap));

  task automatic endSim();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failCount++;
      endSim();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  // One access; the answer is captured at the falling edge after the taking edge.
  task automatic acc(input logic w, input logic io, input logic isa, input logic [7:0] a,
                     input logic [15:0] d);
    @(negedge sys_clk);
    req = '{wr: w, rd: ~w, ioSpace: io, isaMaster: isa, addr: a, wdata: d};
    @(negedge sys_clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    last = resp;
  endtask

  task automatic cw(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic cr(input string what, input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, 1'b0, 1'b0, a, 16'h0000);
    chk({what, " valid"}, 16'h0001, last.rvalid);
    chk(what, e, last.rdata);
  endtask

  task automatic runLen(input logic lvl, output int k);
    k = 0;
    while (stopN === lvl && k < 2000)
    begin
      @(negedge sys_clk);
      k++;
    end
  endtask

  initial
  begin
    cyc(4);
    rst_n = 1'b1;
    intrIn = 1'b1;
    cyc(3);
    chk("cpu pins off", 16'h0000, {cpu_reset_out, smiN, stopN, intrOut, nmiOut, ignN});
    chk("pci isa reset", 16'h0001, {pciRstN, isaRst});
    pg = 1'b1;
    n = 0;
    while (pciRstN !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk("cpu held", 16'h0001, cpu_reset_out);
    n = 0;
    while (cpu_reset_out !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk("reset gap", 16'h0001, n >= GAP - 1 && n <= GAP + 1);
    chk("run", 16'h005d, {pciRstN, isaRst, div4, dma, intrOut, nmiOut, ignN});
    $display("test power done");

    acc(1'b1, 1'b1, 1'b0, `IO_APM_MAILBOX, 16'h005a);
    chk("claim forward", 16'h0003, {last.claim, last.forward});
    acc(1'b1, 1'b1, 1'b1, `IO_APM_MAILBOX, 16'h00c3);
    chk("isa claim", 16'h0000, {last.claim, last.forward});
    acc(1'b0, 1'b1, 1'b0, `IO_APM_MAILBOX, 16'h0000);
    chk("mailbox", 16'h005a, last.rdata);
    cr("unmapped", 8'h10, 16'h0000);
    cr("control reset", `CFG_SMI_CONTROL, 16'h0000);
    $display("test decode done");

    cw(`CFG_SMI_CONTROL, 16'h0001);
    acc(1'b1, 1'b1, 1'b1, `IO_APM_COMMAND, 16'h0000);
    cyc(2);
    chk("isa no smi", 16'h0001, smiN);
    acc(1'b1, 1'b1, 1'b0, `IO_APM_COMMAND, 16'h0000);
    cyc(1);
    chk("apm smi", 16'h0000, smiN);
    cr("cause apm", `CFG_SMI_CAUSE, 16'h0002);
    cw(`CFG_SMI_CAUSE, 16'h0002);
    cyc(1);
    chk("smi cleared", 16'h0001, smiN);
    cw(`CFG_SMI_CONTROL, 16'h0000);
    acc(1'b1, 1'b1, 1'b0, `IO_APM_COMMAND, 16'h0000);
    cyc(2);
    chk("global off", 16'h0001, smiN);
    cw(`CFG_SMI_CAUSE, 16'h0002);
    cw(`CFG_SMI_CONTROL, 16'h0001);
    extN = 1'b0;
    cyc(8);
    chk("ext masked", 16'h0001, smiN);
    cw(`CFG_SMI_ENABLE, 16'h0001);
    cyc(3);
    chk("ext smi", 16'h0000, smiN);
    extN = 1'b1;
    cyc(6);
    cr("cause ext", `CFG_SMI_CAUSE, 16'h0001);
    chk("smi held", 16'h0000, smiN);
    cw(`CFG_SMI_CAUSE, 16'h0001);
    cyc(1);
    chk("ext cleared", 16'h0001, smiN);
    cw(`CFG_HANDSHAKE, 16'ha500);
    cr("handshake", `CFG_HANDSHAKE, 16'ha500);
    $display("test smi done");

    cw(`CFG_SMI_CONTROL, 16'h0002);
    acc(1'b0, 1'b1, 1'b0, `IO_APM_COMMAND, 16'h0000);
    cyc(3);
    chk("stop on", 16'h0001, {stopN, stopGrant});
    cw(`CFG_BREAK_ENABLE, 16'h0001);
    brk = 8'h02;
    cyc(6);
    chk("break masked", 16'h0000, stopN);
    brk = 8'h01;
    cyc(7);
    chk("break", 16'h0002, {stopN, stopGrant});
    brk = 8'h00;
    cyc(3);
    acc(1'b0, 1'b1, 1'b0, `IO_APM_COMMAND, 16'h0000);
    cyc(3);
    chk("stop again", 16'h0000, stopN);
    cw(`CFG_SMI_CONTROL, 16'h0000);
    cyc(2);
    chk("stop disabled", 16'h0001, stopN);
    cw(`CFG_SMI_CONTROL, 16'h0002);
    acc(1'b0, 1'b1, 1'b0, `IO_APM_COMMAND, 16'h0000);
    cyc(3);
    chk("stop before write", 16'h0000, stopN);
    acc(1'b1, 1'b1, 1'b0, `IO_APM_COMMAND, 16'h0000);
    cyc(2);
    chk("stop by write", 16'h0001, stopN);
    cw(`CFG_SMI_CAUSE, 16'h0002);
    $display("test stop done");

    cw(`CFG_SCALE_RUN, 16'h0002);
    cw(`CFG_SCALE_STOP, 16'h0003);
    cw(`CFG_SMI_CONTROL, 16'h0004);
    runLen(1'b1, n);
    runLen(1'b0, n);
    chk("stop time", 16'(3 * TICK), n[15:0]);
    runLen(1'b1, n);
    chk("run time", 16'(2 * TICK), n[15:0]);
    cw(`CFG_SMI_CONTROL, 16'h0000);
    $display("test scaling done");

    strapSel = 1'b1;
    tc = 1'b0;
    cw(`CFG_RESET_CONTROL, 16'h0004);
    cyc(4);
    chk("hard reset", 16'h0005, {cpu_reset_out, pciRstN, isaRst});
    n = 0;
    while (cpu_reset_out !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk("divide 3 external dma", 16'h0000, {div4, dma});
    $display("test hard reset done");
    endSim();
  end
endmodule
